// >>> verilog/irqef_top.sv
// Purpose: Request enable register, global request, pin drive and error flags
// Assumes: Receive events are one-cycle pulses from same-clock logic
// Notes: IRQ pin is split into output, output enable and input
//
// Strobed register access is this design's own decision.

// Functional notes
// - Enable bit 7 high drives pin push-pull, low drives open-drain.
// - Global request reaches the pin only while enable bit 6 is set.
// - Card detect request counts only while enable bit 5 is set.
// - Enable bits 4..0 gate timer underflow requests 4..0.
// - Error bit 7 sets when the last memory command failed.
// - Bit 6 sets on FIFO write during CRC, rx phases or authentication.
// - Misuse clears at new command, or after flags appended in multi-frame mode.
// - Write to full FIFO sets bit 5; later writes are discarded.
// - Bit 4 sets when valid start of frame has under four data bits.
// - Short frames dropped silently, decoder stays on, no receive-done request.
// - Frame error flags clear at receive start or wait-for-data entry.
// - Bit 3 sets when transmit needed but FIFO empty.
// - Bit 2 sets on collision; first collision position is recorded.
// - Collision within end-of-frame symbol does not set collision flag.
// - Bit 1 sets and reception stops on stop bit, frame or count error.
// - On protocol error the last received byte is stored only when a FIFO write is accepted in the same cycle.
// - Bit 0 sets on parity or CRC mismatch; reception continues.
// - With collision-as-integrity set, collisions also set integrity flag.
// - Error request set when misuse, overflow, protocol, empty or integrity set.
// - Global request set when any enabled request is active.
module irqef_top
   import irqef_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [irqef_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [irqef_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [irqef_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic [irqef_pkg::NUM_TIMERS-1:0] TIMER_UNDERFLOW_REQUEST,
   input wire logic CARD_DETECT_REQUEST,
   input wire logic FIRST_ENABLED_REQUEST,
   input wire logic NVM_CMD_DONE,
   input wire logic NVM_CMD_FAIL,
   input wire logic [2:0] TRX_PHASE,
   input wire logic CRC_TX_WINDOW,
   input wire logic AUTH_ACTIVE,
   input wire logic CMD_START,
   input wire logic CMD_IS_RECEIVE,
   input wire logic MULTI_FRAME_RECEIVE,
   input wire logic FLAGS_APPENDED,
   input wire logic FIFO_WR,
   input wire logic [irqef_pkg::DATA_W-1:0] FIFO_WDATA,
   input wire logic FIFO_FULL,
   input wire logic FIFO_EMPTY,
   input wire logic TX_NEEDED,
   input wire logic RX_FRAME_END,
   input wire logic [3:0] RX_FRAME_BITS,
   input wire logic [1:0] RX_FRAME_BYTES,
   input wire logic RX_BYTE_VALID,
   input wire logic [irqef_pkg::DATA_W-1:0] RX_BYTE,
   input wire logic RX_COLLISION,
   input wire logic RX_COLL_IN_EOF,
   input wire logic [irqef_pkg::COLL_POS_W-1:0] RX_COLL_BITPOS,
   input wire logic RX_COLL_POS_OK,
   input wire logic RX_BAD_STOP,
   input wire logic RX_BAD_FRAMING,
   input wire logic RX_BAD_COUNT,
   input wire logic RX_INTEGRITY_FAIL,
   output logic FIFO_STORE,
   output logic [irqef_pkg::DATA_W-1:0] FIFO_STORE_DATA,
   output logic RECEIVE_DONE_REQUEST,
   output logic RECEIVE_DECODER_ENABLE,
   output logic RX_STOP,
   output logic ERROR_REQUEST,
   output logic GLOBAL_REQUEST,
   input wire logic IRQ_PIN_I,
   output logic IRQ_PIN_O,
   output logic IRQ_PIN_OE
);
   import irqef_pkg::*;

   typedef enum logic [2:0] {
      IRQEF_RX_IDLE = 3'b001,
      IRQEF_RX_ACTIVE = 3'b010,
      IRQEF_RX_HALTED = 3'b100
   } irqef_rx_t;

   logic [DATA_W-1:0] req_en_ff;
   logic [DATA_W-1:0] err_ff;
   logic [DATA_W-1:0] rx_cfg_ff;
   logic [DATA_W-1:0] coll_pos_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] store_data_ff;
   logic store_ff;
   logic rx_done_ff;
   logic global_ff;
   logic err_req_ff;
   logic pin_sync1_ff;
   logic pin_sync2_ff;
   irqef_rx_t rx_st_ff;
   irqef_rx_t nxt_rx_st;
   logic [DATA_W-1:0] nxt_err;
   logic [DATA_W-1:0] nxt_coll_pos;
   logic [DATA_W-1:0] err_set;
   logic [DATA_W-1:0] err_clr;
   logic [NUM_TIMERS:0] gated;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   irqef_gate u_gate (
      .TIMER_REQ(TIMER_UNDERFLOW_REQUEST),
      .CARD_REQ(CARD_DETECT_REQUEST),
      .ENABLES(req_en_ff),
      .GATED(gated)
   );

   // Decode of receive phases
   wire in_rx_phase = (TRX_PHASE == PH_RX_WAIT) || (TRX_PHASE == PH_WAIT_DATA) || (TRX_PHASE == PH_RECEIVING);
   wire wait_data_entry = (TRX_PHASE == PH_WAIT_DATA) && !CMD_IS_RECEIVE;
   wire prot_hit = RX_BAD_STOP | RX_BAD_FRAMING | RX_BAD_COUNT;
   wire coll_hit = RX_COLLISION && !RX_COLL_IN_EOF;
   wire short_bits = RX_FRAME_END && (RX_FRAME_BITS < MIN_FRAME_BITS);
   wire short_noise = RX_FRAME_END && rx_cfg_ff[BIT_NOISE_SUPP] && (RX_FRAME_BYTES < MIN_NOISE_BYTES);
   wire frame_dropped = short_bits || short_noise;
   wire fifo_accept = FIFO_WR && !FIFO_FULL && !err_ff[BIT_FIFO_OVF];
   wire rx_running = (rx_st_ff == IRQEF_RX_ACTIVE);
   wire first_coll = coll_hit && !err_ff[BIT_COLLISION];

   // Set terms; sets win over clears below
   assign err_set[BIT_NVM_ERR] = NVM_CMD_DONE && NVM_CMD_FAIL;
   assign err_set[BIT_FIFO_MISUSE] = FIFO_WR && (CRC_TX_WINDOW || in_rx_phase || AUTH_ACTIVE);
   assign err_set[BIT_FIFO_OVF] = FIFO_WR && FIFO_FULL;
   assign err_set[BIT_SHORT_FRAME] = short_bits;
   assign err_set[BIT_EMPTY_TX] = TX_NEEDED && FIFO_EMPTY;
   assign err_set[BIT_COLLISION] = coll_hit;
   assign err_set[BIT_PROTOCOL] = prot_hit && rx_running;
   assign err_set[BIT_INTEGRITY] = RX_INTEGRITY_FAIL || (coll_hit && rx_cfg_ff[BIT_COLL_AS_INTEG]);

   // Clear terms
   wire rx_flags_clr = (CMD_START && CMD_IS_RECEIVE) || wait_data_entry;
   wire misuse_clr = MULTI_FRAME_RECEIVE ? FLAGS_APPENDED : CMD_START;
   wire nvm_clr = NVM_CMD_DONE && !NVM_CMD_FAIL;
   assign err_clr[BIT_NVM_ERR] = nvm_clr;
   assign err_clr[BIT_FIFO_MISUSE] = misuse_clr;
   assign err_clr[BIT_FIFO_OVF] = CMD_START;
   assign err_clr[BIT_SHORT_FRAME] = rx_flags_clr;
   assign err_clr[BIT_EMPTY_TX] = CMD_START;
   assign err_clr[BIT_COLLISION] = rx_flags_clr;
   assign err_clr[BIT_PROTOCOL] = rx_flags_clr;
   assign err_clr[BIT_INTEGRITY] = rx_flags_clr;

   assign nxt_err = err_set | (err_ff & ~err_clr);

   // First collision only; position register cleared with the flags
   assign nxt_coll_pos = first_coll ? {RX_COLL_POS_OK, RX_COLL_BITPOS} :
                         (rx_flags_clr ? RST_COLL_POS : coll_pos_ff);

   // Protocol error halts the decoder until the next command start or wait-for-data entry
   always_comb begin
      nxt_rx_st = rx_st_ff;
      unique case (rx_st_ff)
         IRQEF_RX_IDLE: begin
            if (rx_flags_clr || CMD_START) begin
               nxt_rx_st = IRQEF_RX_ACTIVE;
            end
         end
         IRQEF_RX_ACTIVE: begin
            if (prot_hit) begin
               nxt_rx_st = IRQEF_RX_HALTED;
            end else if (TRX_PHASE == PH_IDLE) begin
               nxt_rx_st = IRQEF_RX_IDLE;
            end
         end
         IRQEF_RX_HALTED: begin
            if (rx_flags_clr || CMD_START) begin
               nxt_rx_st = IRQEF_RX_ACTIVE;
            end
         end
         default: begin
            nxt_rx_st = IRQEF_RX_IDLE;
         end
      endcase
   end

   // Error request over the five listed flags
   wire err_req_any = nxt_err[BIT_FIFO_MISUSE] | nxt_err[BIT_FIFO_OVF] | nxt_err[BIT_PROTOCOL] |
                      nxt_err[BIT_EMPTY_TX] | nxt_err[BIT_INTEGRITY];

   // Enabled requests of both registers ORed each cycle
   wire global_any = (|gated) | FIRST_ENABLED_REQUEST;

   // Read mux; unmapped addresses read zero
   wire [DATA_W-1:0] rd_mux = hit(REG_ADDR, OFS_REQ_EN) ? req_en_ff :
                              hit(REG_ADDR, OFS_ERR_FLAGS) ? err_ff :
                              hit(REG_ADDR, OFS_RX_CFG) ? rx_cfg_ff :
                              hit(REG_ADDR, OFS_COLL_POS) ? coll_pos_ff :
                              hit(REG_ADDR, OFS_ERR_REQ) ? {{(DATA_W-1){1'b0}}, err_req_ff} :
                              {DATA_W{1'b0}};

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         req_en_ff <= RST_REQ_EN;
         rx_cfg_ff <= RST_RX_CFG;
      end else if (REG_WR) begin
         if (hit(REG_ADDR, OFS_REQ_EN)) begin
            req_en_ff <= REG_WDATA;
         end
         if (hit(REG_ADDR, OFS_RX_CFG)) begin
            rx_cfg_ff <= REG_WDATA;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         err_ff <= RST_ERR_FLAGS;
         coll_pos_ff <= RST_COLL_POS;
         rx_st_ff <= IRQEF_RX_IDLE;
         err_req_ff <= 1'b0;
         global_ff <= 1'b0;
      end else begin
         err_ff <= nxt_err;
         coll_pos_ff <= nxt_coll_pos;
         rx_st_ff <= nxt_rx_st;
         err_req_ff <= err_req_any;
         global_ff <= global_any;
      end
   end

   // Receive data path; a byte seen with a protocol error is stored only when a FIFO write is accepted in that cycle
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         store_ff <= 1'b0;
         store_data_ff <= {DATA_W{1'b0}};
         rx_done_ff <= 1'b0;
      end else begin
         store_ff <= (RX_BYTE_VALID && rx_running && !prot_hit) || fifo_accept;
         if (RX_BYTE_VALID) begin
            store_data_ff <= RX_BYTE;
         end else if (fifo_accept) begin
            store_data_ff <= FIFO_WDATA;
         end
         rx_done_ff <= RX_FRAME_END && !frame_dropped;
      end
   end

   // Pin synchroniser, output unused and not read back
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pin_sync1_ff <= 1'b0;
         pin_sync2_ff <= 1'b0;
         rdata_ff <= {DATA_W{1'b0}};
      end else begin
         pin_sync1_ff <= IRQ_PIN_I;
         pin_sync2_ff <= pin_sync1_ff;
         rdata_ff <= REG_RD ? rd_mux : {DATA_W{1'b0}};
      end
   end

   // Pin drive; open-drain only pulls low when asserted
   wire pin_active = global_ff && req_en_ff[BIT_PIN_GATE];
   assign IRQ_PIN_O = req_en_ff[BIT_DRIVE_SEL] ? pin_active : 1'b0;
   assign IRQ_PIN_OE = req_en_ff[BIT_DRIVE_SEL] ? 1'b1 : pin_active;

   assign REG_RDATA = rdata_ff;
   assign FIFO_STORE = store_ff;
   assign FIFO_STORE_DATA = store_data_ff;
   assign RECEIVE_DONE_REQUEST = rx_done_ff;
   assign RECEIVE_DECODER_ENABLE = (rx_st_ff != IRQEF_RX_HALTED);
   assign RX_STOP = (rx_st_ff == IRQEF_RX_HALTED);
   assign ERROR_REQUEST = err_req_ff;
   assign GLOBAL_REQUEST = global_ff;
endmodule : irqef_top

// >>> verilog/irqef_pkg.sv
// Purpose: Shared constants for the request enable and error flag block
// Assumes: 8-bit register port, 125 MHz clock
// Notes: Offsets are register indices on the plain port
package irqef_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFS_REQ_EN = 8'h09;
   localparam logic [ADDR_W-1:0] OFS_ERR_FLAGS = 8'h0a;
   localparam logic [ADDR_W-1:0] OFS_RX_CFG = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_COLL_POS = 8'h0d;
   localparam logic [ADDR_W-1:0] OFS_ERR_REQ = 8'h0e;
   localparam logic [DATA_W-1:0] RST_REQ_EN = 8'h00;
   localparam logic [DATA_W-1:0] RST_ERR_FLAGS = 8'h00;
   localparam logic [DATA_W-1:0] RST_RX_CFG = 8'h00;
   localparam logic [DATA_W-1:0] RST_COLL_POS = 8'h00;
   // Enable register fields
   localparam int unsigned BIT_DRIVE_SEL = 7;
   localparam int unsigned BIT_PIN_GATE = 6;
   localparam int unsigned BIT_CARD_EN = 5;
   localparam int unsigned NUM_TIMERS = 5;
   // Error flag fields
   localparam int unsigned BIT_NVM_ERR = 7;
   localparam int unsigned BIT_FIFO_MISUSE = 6;
   localparam int unsigned BIT_FIFO_OVF = 5;
   localparam int unsigned BIT_SHORT_FRAME = 4;
   localparam int unsigned BIT_EMPTY_TX = 3;
   localparam int unsigned BIT_COLLISION = 2;
   localparam int unsigned BIT_PROTOCOL = 1;
   localparam int unsigned BIT_INTEGRITY = 0;
   // Receive config and collision position fields
   localparam int unsigned BIT_COLL_AS_INTEG = 3;
   localparam int unsigned BIT_NOISE_SUPP = 0;
   localparam int unsigned BIT_COLL_VALID = 7;
   localparam int unsigned COLL_POS_W = 7;
   // Frame length thresholds
   localparam logic [3:0] MIN_FRAME_BITS = 4'h4;
   localparam logic [1:0] MIN_NOISE_BYTES = 2'h3;
   // Transceiver phase codes
   localparam logic [2:0] PH_IDLE = 3'h0;
   localparam logic [2:0] PH_RX_WAIT = 3'h5;
   localparam logic [2:0] PH_WAIT_DATA = 3'h6;
   localparam logic [2:0] PH_RECEIVING = 3'h7;
endpackage : irqef_pkg

// >>> verilog/irqef_gate.sv
// Purpose: Enable gating of the timer and card detect requests
// Assumes: Requests are same-clock levels
// Notes: Purely combinational
module irqef_gate
   import irqef_pkg::*;
(
   input wire logic [irqef_pkg::NUM_TIMERS-1:0] TIMER_REQ,
   input wire logic CARD_REQ,
   input wire logic [irqef_pkg::DATA_W-1:0] ENABLES,
   output logic [irqef_pkg::NUM_TIMERS:0] GATED
);
   genvar i;
   generate
      for (i = 0; i < NUM_TIMERS; i++) begin : g_tmr
         assign GATED[i] = TIMER_REQ[i] & ENABLES[i];
      end
   endgenerate
   assign GATED[NUM_TIMERS] = CARD_REQ & ENABLES[BIT_CARD_EN];
endmodule : irqef_gate

// >>> sim/irqef_chk.sv
// Purpose: Port checker for the request enable and error flag block
// Assumes: Enable register mirrored from bus writes
// Notes: Bound to irqef_top below
module irqef_chk
   import irqef_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [irqef_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [irqef_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [irqef_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic [irqef_pkg::NUM_TIMERS-1:0] TIMER_UNDERFLOW_REQUEST,
   input wire logic CARD_DETECT_REQUEST,
   input wire logic FIRST_ENABLED_REQUEST,
   input wire logic GLOBAL_REQUEST,
   input wire logic IRQ_PIN_O,
   input wire logic IRQ_PIN_OE,
   input wire logic FIFO_WR,
   input wire logic FIFO_FULL,
   input wire logic FIFO_STORE,
   input wire logic RX_BYTE_VALID,
   input wire logic RX_BAD_STOP,
   input wire logic RX_FRAME_END,
   input wire logic [3:0] RX_FRAME_BITS,
   input wire logic RECEIVE_DONE_REQUEST
);
   logic [7:0] en_ff;
   wire logic en_wr = REG_WR && REG_ADDR == OFS_REQ_EN;
   wire logic [7:0] nxt_en = en_wr ? REG_WDATA : en_ff;
   wire logic gq_cause = |(TIMER_UNDERFLOW_REQUEST & en_ff[4:0]) | (CARD_DETECT_REQUEST & en_ff[5]) |
      FIRST_ENABLED_REQUEST;
   wire logic pin_act = GLOBAL_REQUEST & en_ff[6];
   always_ff @(posedge CLK) en_ff <= SYS_RST ? RST_REQ_EN : nxt_en;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   push_pull_a: assert property (en_ff[7] |-> IRQ_PIN_OE && IRQ_PIN_O == pin_act)
      else $error("push-pull drive wrong");
   open_drain_a: assert property (!en_ff[7] |-> !IRQ_PIN_O && IRQ_PIN_OE == pin_act)
      else $error("open-drain drive wrong");
   pin_gate_a: assert property (!en_ff[6] |-> !(IRQ_PIN_O || (IRQ_PIN_OE && !en_ff[7])))
      else $error("pin active while gated");
   global_req_a: assert property (!$past(SYS_RST) |-> GLOBAL_REQUEST == $past(gq_cause))
      else $error("global request wrong");
   rd_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
      else $error("read data outside read slot");
   rd_enable_a: assert property ($past(REG_RD && REG_ADDR == OFS_REQ_EN) |-> REG_RDATA == $past(en_ff))
      else $error("enable readback wrong");
   ovf_drop_a: assert property (FIFO_WR && FIFO_FULL && !RX_BYTE_VALID |=> !FIFO_STORE)
      else $error("write to full store accepted");
   prot_drop_a: assert property (RX_BYTE_VALID && RX_BAD_STOP && !FIFO_WR |=> !FIFO_STORE)
      else $error("byte stored on bad stop");
   short_drop_a: assert property (RX_FRAME_END && RX_FRAME_BITS < MIN_FRAME_BITS |=> !RECEIVE_DONE_REQUEST)
      else $error("done raised on short frame");
   cover property (en_ff[7] && pin_act);
   cover property ($rose(GLOBAL_REQUEST));
   cover property (RX_FRAME_END && RX_FRAME_BITS < MIN_FRAME_BITS);
endmodule : irqef_chk

bind irqef_top irqef_chk u_chk (.*);

// >>> sim/irqef_host.sv
// Purpose: Host side of the interrupt pin
// Assumes: Board pull-up on the pin
// Notes: Released pin reads high, never the last driven value
module irqef_host (
   input wire logic pin_o,
   input wire logic pin_oe,
   output logic pin_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_lvl = pin_oe ? pin_o : 1'h1;
endmodule : irqef_host

// >>> sim/tb_irq_enable_and_error_flags.sv
// Purpose: Self-checking bench for the request enable and error flag block
// Assumes: 125 MHz clock, register port without wait states
// Notes: Rows are {enable, timers, card, global, pin}
module tb_irq_enable_and_error_flags import irqef_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = '0, SYS_RST = 1'h1, REG_WR = '0, REG_RD = '0, CARD_DETECT_REQUEST = '0, FIRST_ENABLED_REQUEST = '0;
   logic NVM_CMD_DONE = '0, NVM_CMD_FAIL = '0, CRC_TX_WINDOW = '0, AUTH_ACTIVE = '0, CMD_START = '0;
   logic CMD_IS_RECEIVE = '0, MULTI_FRAME_RECEIVE = '0, FLAGS_APPENDED = '0, FIFO_WR = '0, FIFO_FULL = '0;
   logic FIFO_EMPTY = '0, TX_NEEDED = '0, RX_FRAME_END = '0, RX_BYTE_VALID = '0, RX_COLLISION = '0;
   logic RX_COLL_IN_EOF = '0, RX_COLL_POS_OK = '0, RX_BAD_STOP = '0, RX_BAD_FRAMING = '0, RX_BAD_COUNT = '0;
   logic RX_INTEGRITY_FAIL = '0;
   logic [7:0] REG_ADDR = '0, REG_WDATA = '0, FIFO_WDATA = 8'h5a, RX_BYTE = 8'ha5, REG_RDATA, FIFO_STORE_DATA;
   logic [4:0] TIMER_UNDERFLOW_REQUEST = '0;
   logic [3:0] RX_FRAME_BITS = '0;
   logic [2:0] TRX_PHASE = '0;
   logic [1:0] RX_FRAME_BYTES = '0;
   logic [6:0] RX_COLL_BITPOS = 7'h05;
   logic FIFO_STORE, RECEIVE_DONE_REQUEST, RECEIVE_DECODER_ENABLE, RX_STOP, ERROR_REQUEST, GLOBAL_REQUEST;
   logic IRQ_PIN_I, IRQ_PIN_O, IRQ_PIN_OE;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   logic [15:0] rows [12] = '{16'h00fd, 16'h010b, 16'h410a, 16'hc10b, 16'hc208, 16'h5082,
      16'h6006, 16'h5f05, 16'h4842, 16'h4422, 16'h4212, 16'h4f81};
   irqef_top DUT (.*);
   irqef_host u_host (.pin_o(IRQ_PIN_O), .pin_oe(IRQ_PIN_OE), .pin_lvl(IRQ_PIN_I));
   initial forever #4 CLK = ~CLK;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK) REG_WR <= 1'h1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK) REG_WR <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK) REG_RD <= 1'h1;
      REG_ADDR <= a;
      @(posedge CLK) REG_RD <= 1'h0;
      #1 chk(REG_RDATA, exp);
   endtask : rd
   task automatic start_cmd(input logic rx);
      @(posedge CLK) CMD_START <= 1'h1;
      CMD_IS_RECEIVE <= rx;
      @(posedge CLK) CMD_START <= 1'h0;
   endtask : start_cmd
   // Bounded run, tests need well under a thousand cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge CLK);
      SYS_RST <= 1'h0;
      rd(OFS_REQ_EN, RST_REQ_EN);
      rd(8'h33, 8'h00);
      wr(OFS_ERR_FLAGS, 8'hff);
      rd(OFS_ERR_FLAGS, RST_ERR_FLAGS);
      foreach (rows[i]) begin
         wr(OFS_REQ_EN, rows[i][15:8]);
         TIMER_UNDERFLOW_REQUEST <= rows[i][7:3];
         CARD_DETECT_REQUEST <= rows[i][2];
         repeat (2) @(posedge CLK);
         #1 chk(8'(GLOBAL_REQUEST), 8'(rows[i][1]));
         chk(8'(IRQ_PIN_I), 8'(rows[i][0]));
         rd(OFS_REQ_EN, rows[i][15:8]);
      end
      @(posedge CLK) FIRST_ENABLED_REQUEST <= 1'h1;
      repeat (2) @(posedge CLK);
      #1 chk(8'(GLOBAL_REQUEST), 8'h01);
      @(posedge CLK) FIRST_ENABLED_REQUEST <= 1'h0;
      TIMER_UNDERFLOW_REQUEST <= '0;
      NVM_CMD_DONE <= 1'h1;
      NVM_CMD_FAIL <= 1'h1;
      @(posedge CLK) NVM_CMD_DONE <= 1'h0;
      rd(OFS_ERR_FLAGS, 8'h80);
      chk(8'(ERROR_REQUEST), 8'h00);
      @(posedge CLK) NVM_CMD_DONE <= 1'h1;
      NVM_CMD_FAIL <= 1'h0;
      @(posedge CLK) NVM_CMD_DONE <= 1'h0;
      // Phase codes 5..7 follow i+3
      for (int i = 0; i < 5; i++) begin
         start_cmd(1'h0);
         @(posedge CLK) CRC_TX_WINDOW <= (i == 0);
         AUTH_ACTIVE <= (i == 1);
         TRX_PHASE <= (i < 2) ? PH_IDLE : 3'(i + 3);
         FIFO_WR <= 1'h1;
         @(posedge CLK) FIFO_WR <= 1'h0;
         rd(OFS_ERR_FLAGS, 8'h40);
         chk(8'(ERROR_REQUEST), 8'h01);
      end
      @(posedge CLK) TRX_PHASE <= PH_IDLE;
      CRC_TX_WINDOW <= 1'h0;
      AUTH_ACTIVE <= 1'h0;
      start_cmd(1'h0);
      rd(OFS_ERR_FLAGS, 8'h00);
      @(posedge CLK) MULTI_FRAME_RECEIVE <= 1'h1;
      TRX_PHASE <= PH_RX_WAIT;
      FIFO_WR <= 1'h1;
      @(posedge CLK) FIFO_WR <= 1'h0;
      FLAGS_APPENDED <= 1'h1;
      #1 chk(FIFO_STORE_DATA, 8'h5a);
      @(posedge CLK) FLAGS_APPENDED <= 1'h0;
      rd(OFS_ERR_FLAGS, 8'h00);
      @(posedge CLK) MULTI_FRAME_RECEIVE <= 1'h0;
      TRX_PHASE <= PH_IDLE;
      FIFO_FULL <= 1'h1;
      FIFO_WR <= 1'h1;
      @(posedge CLK) FIFO_FULL <= 1'h0;
      @(posedge CLK) FIFO_WR <= 1'h0;
      #1 chk(8'(FIFO_STORE), 8'h00);
      rd(OFS_ERR_FLAGS, 8'h20);
      start_cmd(1'h0);
      @(posedge CLK) FIFO_EMPTY <= 1'h1;
      TX_NEEDED <= 1'h1;
      @(posedge CLK) TX_NEEDED <= 1'h0;
      rd(OFS_ERR_FLAGS, 8'h08);
      start_cmd(1'h1);
      @(posedge CLK) RX_FRAME_END <= 1'h1;
      RX_FRAME_BITS <= 4'h3;
      @(posedge CLK) RX_FRAME_BITS <= MIN_FRAME_BITS;
      #1 chk(8'(RECEIVE_DONE_REQUEST), 8'h00);
      chk(8'(RECEIVE_DECODER_ENABLE), 8'h01);
      @(posedge CLK) RX_FRAME_END <= 1'h0;
      #1 chk(8'(RECEIVE_DONE_REQUEST), 8'h01);
      rd(OFS_ERR_FLAGS, 8'h10);
      @(posedge CLK) RX_COLLISION <= 1'h1;
      RX_COLL_IN_EOF <= 1'h1;
      @(posedge CLK) RX_COLLISION <= 1'h0;
      rd(OFS_ERR_FLAGS, 8'h10);
      @(posedge CLK) RX_COLLISION <= 1'h1;
      RX_COLL_IN_EOF <= 1'h0;
      RX_COLL_POS_OK <= 1'h1;
      @(posedge CLK) RX_COLL_BITPOS <= 7'h09;
      @(posedge CLK) RX_COLLISION <= 1'h0;
      rd(OFS_COLL_POS, 8'h85);
      @(posedge CLK) RX_INTEGRITY_FAIL <= 1'h1;
      @(posedge CLK) RX_INTEGRITY_FAIL <= 1'h0;
      #1 chk(8'(RX_STOP), 8'h00);
      rd(OFS_ERR_FLAGS, 8'h15);
      start_cmd(1'h0);
      rd(OFS_ERR_FLAGS, 8'h15);
      @(posedge CLK) TRX_PHASE <= PH_WAIT_DATA;
      rd(OFS_ERR_FLAGS, 8'h00);
      @(posedge CLK) TRX_PHASE <= PH_IDLE;
      wr(OFS_RX_CFG, 8'h08);
      start_cmd(1'h1);
      @(posedge CLK) RX_COLLISION <= 1'h1;
      @(posedge CLK) RX_COLLISION <= 1'h0;
      rd(OFS_ERR_FLAGS, 8'h05);
      // Receive must stay active, an idle phase drops the decoder to idle
      @(posedge CLK) TRX_PHASE <= PH_RECEIVING;
      for (int k = 0; k < 3; k++) begin
         start_cmd(1'h1);
         @(posedge CLK) {RX_BAD_STOP, RX_BAD_FRAMING, RX_BAD_COUNT} <= 3'h4 >> k;
         RX_BYTE_VALID <= 1'h1;
         @(posedge CLK) {RX_BAD_STOP, RX_BAD_FRAMING, RX_BAD_COUNT} <= 3'h0;
         RX_BYTE_VALID <= 1'h0;
         #1 chk(8'(FIFO_STORE), 8'h00);
         chk(8'(RX_STOP), 8'h01);
         rd(OFS_ERR_FLAGS, 8'h02);
      end
      // Mid-run reset must drop flags and config
      @(posedge CLK) SYS_RST <= 1'h1;
      @(posedge CLK) SYS_RST <= 1'h0;
      rd(OFS_ERR_FLAGS, RST_ERR_FLAGS);
      rd(OFS_RX_CFG, RST_RX_CFG);
      close_out();
   end
endmodule : tb_irq_enable_and_error_flags
